// ### hdl/spi_serial_port_pkg.sv
// constants, states and timing for the serial port
package spi_serial_port_pkg;
    localparam int WORD_BITS = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCK_HALF_NS = 80;
    // half period of the master shift clock, a least time so rounded up
    localparam logic [2:0] SCK_HALF_CYCLES =
        3'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic SCK_IDLE_RESET = 1'b0;
    localparam logic SS_IDLE_RESET = 1'b1;
    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SHIFT} xfer_state_e;
endpackage

// ### hdl/word_fifo.sv
// first-in first-out word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] count;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
    } fifo_s;
    fifo_s st;
    fifo_s next_st;
    logic push;
    logic pop;

    assign in_ready = st.count != FULL_COUNT;
    assign out_valid = st.count != '0;
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = AW'(st.wr + 1'b1);
        end
        if (pop) begin
            next_st.rd = AW'(st.rd + 1'b1);
        end
        next_st.count = (AW+1)'(st.count + push - pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ### hdl/spi_serial_port.sv
// serial peripheral port: master, slave and framed operation
// Summary of operation
// - 16-bit shift register apart from transfer buffer
// - master drives shift clock, slave receives it
// - slave select low selects, high deselects
// - framed: clock continuous, sync pulse starts frame
// - sample phase accepted only with master set
// - transfer start copies buffer, buffer becomes empty
`timescale 1ns/1ps
`default_nettype none
module spi_serial_port
    import spi_serial_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cfg_write,
    input wire logic cfg_port_enable,
    input wire logic cfg_master_mode_enable,
    input wire logic cfg_input_sample_phase,
    input wire logic cfg_clock_idle_polarity,
    input wire logic cfg_slave_select_pin_enable,
    input wire logic cfg_framed_mode_enable,
    input wire logic cfg_frame_sync_polarity,
    input wire logic [15:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [15:0] rx_data,
    output logic rx_valid,
    output logic busy,
    output logic transfer_buffer_full,
    output logic sample_phase_state,
    output logic config_invalid,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe_n,
    input wire logic shift_clock_in,
    output logic shift_clock_out,
    output logic shift_clock_oe_n,
    input wire logic slave_select_n_in,
    output logic slave_select_n_out,
    output logic slave_select_n_oe_n
);
    typedef struct packed {
        logic enable;
        logic master;
        logic sample_phase;
        logic idle_pol;
        logic ss_enable;
        logic framed;
        logic frame_pol;
        logic [2:0] sck_sync;
        logic [2:0] ss_sync;
        logic [2:0] sin_sync;
        logic sck_f;
        logic ss_f;
        logic sin_f;
        logic [15:0] buffer;
        logic buf_full;
        logic [15:0] shifter;
        logic [3:0] bits;
        logic cap;
        logic loaded;
        logic [2:0] div;
        logic phase;
        xfer_state_e state;
        logic sck;
        logic ss;
        logic sdo;
        logic [15:0] rx_word;
        logic rx_pulse;
    } port_s;
    port_s st;
    port_s next_st;
    logic [15:0] fifo_data;
    logic fifo_valid;
    logic pop;
    logic running;
    logic tick;
    logic lead;
    logic trail;
    logic load;
    logic selected;
    logic in_bit;

    ////////////////////////////////////////////////////////////////
    word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );
    // the buffer only refills once the shifter took it, so a stalled link backs up the fifo
    assign pop = fifo_valid && !st.buf_full;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        tick = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        load = 1'b0;
        in_bit = 1'b0;
        next_st.rx_pulse = 1'b0;
        // pins pass three flops; a level counts once stages two and three agree
        next_st.sck_sync = {st.sck_sync[1:0], shift_clock_in};
        next_st.ss_sync = {st.ss_sync[1:0], slave_select_n_in};
        next_st.sin_sync = {st.sin_sync[1:0], serial_in_pin};
        if (st.sck_sync[1] == st.sck_sync[2]) next_st.sck_f = st.sck_sync[2];
        if (st.ss_sync[1] == st.ss_sync[2]) next_st.ss_f = st.ss_sync[2];
        if (st.sin_sync[1] == st.sin_sync[2]) next_st.sin_f = st.sin_sync[2];
        if (cfg_write) begin
            next_st.enable = cfg_port_enable;
            next_st.master = cfg_master_mode_enable;
            next_st.sample_phase = cfg_input_sample_phase && cfg_master_mode_enable;
            next_st.idle_pol = cfg_clock_idle_polarity;
            next_st.ss_enable = cfg_slave_select_pin_enable;
            next_st.framed = cfg_framed_mode_enable;
            next_st.frame_pol = cfg_frame_sync_polarity;
        end
        if (pop) begin
            next_st.buffer = fifo_data;
            next_st.buf_full = 1'b1;
        end
        // master clock runs only while enabled: in a transfer, or always when framed
        running = st.enable && st.master && (st.framed || st.state != ST_IDLE);
        if (running) begin
            if (st.div == SCK_HALF_CYCLES - 3'h1) begin
                next_st.div = '0;
                tick = 1'b1;
                next_st.phase = !st.phase;
            end else begin
                next_st.div = 3'(st.div + 3'h1);
            end
        end else begin
            next_st.div = '0;
            next_st.phase = 1'b0;
        end
        if (st.master) begin
            lead = tick && !st.phase;
            trail = tick && st.phase;
        end else begin
            lead = (next_st.sck_f ^ st.idle_pol) && !(st.sck_f ^ st.idle_pol);
            trail = !(next_st.sck_f ^ st.idle_pol) && (st.sck_f ^ st.idle_pol);
        end
        selected = !st.ss_enable || !st.ss_f;
        case (st.state)
            ST_IDLE: begin
                next_st.bits = '0;
                if (st.master) begin
                    if (st.buf_full && st.enable && (!st.framed || trail)) begin
                        load = 1'b1;
                        next_st.state = st.framed ? ST_SYNC : ST_SHIFT;
                    end
                end else if (st.framed) begin
                    if (st.enable && trail && st.ss_f == st.frame_pol) begin
                        load = st.buf_full;
                        if (!st.buf_full) next_st.shifter = WORD_RESET;
                        next_st.state = ST_SHIFT;
                    end
                end else if (selected) begin
                    if (!st.loaded && st.buf_full && st.enable) begin
                        load = 1'b1;
                        next_st.loaded = 1'b1;
                    end
                    if (lead) begin
                        next_st.cap = next_st.sin_f;
                        next_st.state = ST_SHIFT;
                    end
                end
            end
            ST_SYNC: begin
                if (trail) next_st.state = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (lead) next_st.cap = next_st.sin_f; // level as it lands: sync eats the half bit
                if (trail) begin
                    // sampling at the end of the bit buys the master a faster clock
                    in_bit = (st.master && st.sample_phase) ? st.sin_f : st.cap;
                    next_st.shifter = {st.shifter[14:0], in_bit};
                    next_st.bits = 4'(st.bits + 4'h1);
                    if (st.bits == LAST_BIT) begin
                        next_st.rx_word = {st.shifter[14:0], in_bit};
                        next_st.rx_pulse = 1'b1;
                        next_st.loaded = 1'b0;
                        next_st.state = ST_IDLE;
                    end
                end
                if (!st.master && !st.framed && !selected) begin
                    next_st.loaded = 1'b0;
                    next_st.state = ST_IDLE;
                end
            end
            default: next_st.state = ST_IDLE;
        endcase
        if (load) begin
            next_st.shifter = st.buffer;
            next_st.buf_full = 1'b0;
        end
        if (!st.enable) next_st.state = ST_IDLE;
        next_st.sck = st.idle_pol ^ next_st.phase;
        if (st.framed) begin
            next_st.ss = (next_st.state == ST_SYNC) ? st.frame_pol : !st.frame_pol;
        end else begin
            next_st.ss = next_st.state == ST_IDLE;
        end
        next_st.sdo = next_st.shifter[15];
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.sck_sync <= SYNC_RESET;
            st.ss_sync <= {3{SS_IDLE_RESET}};
            st.ss_f <= SS_IDLE_RESET;
            st.ss <= SS_IDLE_RESET;
            st.sck <= SCK_IDLE_RESET;
            st.state <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign rx_data = st.rx_word;
    assign rx_valid = st.rx_pulse;
    assign busy = st.state != ST_IDLE;
    assign transfer_buffer_full = st.buf_full;
    assign sample_phase_state = st.sample_phase;
    // both set is a software fault; the framed behaviour wins here
    assign config_invalid = st.framed && st.ss_enable;
    assign serial_out_pin = st.sdo;
    assign serial_out_oe_n = !(st.master || st.framed || selected);
    assign shift_clock_out = st.sck;
    assign shift_clock_oe_n = !st.master;
    assign slave_select_n_out = st.ss;
    assign slave_select_n_oe_n = !(st.master && (st.framed || st.ss_enable));

    ////////////////////////////////////////////////////////////////
    localparam int XFER_MIN = 125;
    localparam int XFER_MAX = 135;

    property p_shift_moves;
        @(posedge clk_sys) disable iff (!reset_n)
        (st.state == ST_SHIFT && trail) |=> st.shifter[15:1] == $past(st.shifter[14:0]);
    endproperty
    a_shift_moves: assert property (p_shift_moves) else $error("shifter did not shift");

    property p_slave_clock_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        (!st.master && !cfg_write) |=> shift_clock_oe_n && st.div == 3'h0;
    endproperty
    a_slave_clock_idle: assert property (p_slave_clock_idle) else $error("slave drove clock");

    property p_deselect_aborts;
        @(posedge clk_sys) disable iff (!reset_n)
        (!st.master && !st.framed && st.ss_enable && st.ss_f && st.state == ST_SHIFT)
            |=> st.state == ST_IDLE;
    endproperty
    a_deselect_aborts: assert property (p_deselect_aborts) else $error("deselect ignored");

    property p_framed_clock_runs;
        @(posedge clk_sys) disable iff (!reset_n)
        (st.master && st.framed && st.enable && tick && !cfg_write)
            |=> shift_clock_out != $past(shift_clock_out);
    endproperty
    a_framed_clock_runs: assert property (p_framed_clock_runs) else $error("frame clock stopped");

    property p_phase_gated;
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_write && !cfg_master_mode_enable) |=> !sample_phase_state;
    endproperty
    a_phase_gated: assert property (p_phase_gated) else $error("sample phase set in slave");

    property p_load_copies;
        @(posedge clk_sys) disable iff (!reset_n)
        load |=> !transfer_buffer_full && st.shifter == $past(st.buffer);
    endproperty
    a_load_copies: assert property (p_load_copies) else $error("buffer not moved");

    property p_word_time;
        @(posedge clk_sys) disable iff (!reset_n)
        (load && st.master && !st.framed && !cfg_write) |-> ##[XFER_MIN:XFER_MAX] rx_valid;
    endproperty
    a_word_time: assert property (p_word_time) else $error("word not exchanged in time");

    c_master_word: cover property (@(posedge clk_sys) disable iff (!reset_n)
        st.master && rx_valid);
    c_slave_word: cover property (@(posedge clk_sys) disable iff (!reset_n)
        !st.master && rx_valid);
    c_frame_sync: cover property (@(posedge clk_sys) disable iff (!reset_n)
        st.state == ST_SYNC ##1 st.state == ST_SHIFT);
endmodule
`default_nettype wire

// ### test/spi_peer.sv
// far-side serial device model: remote slave or remote master
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
    input wire logic act_master,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic sdo,
    output logic sdi,
    output logic peer_sck,
    output logic peer_ss_n
);
    logic [15:0] reply;
    logic [15:0] shreg;
    logic [15:0] gotw;
    logic [15:0] got_q[$];
    initial begin
        sdi = 1'b0;
        peer_sck = 1'b0;
        peer_ss_n = 1'b1;
        reply = 16'h0000;
        shreg = 16'h0000;
        gotw = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // remote slave answers only while select is low
    always @(negedge ss_n) if (!act_master) begin
        shreg = reply;
        sdi = reply[15];
    end
    always @(posedge sck) if (!act_master && !ss_n) gotw = {gotw[14:0], sdo};
    always @(negedge sck) if (!act_master && !ss_n) begin
        shreg = shreg << 1;
        sdi = shreg[15];
    end
    // a released line must not keep showing the last bit
    always @(posedge ss_n) if (!act_master) begin
        got_q.push_back(gotw);
        sdi = ~sdi;
    end
    ////////////////////////////////////////////////////////////////
    // remote master; samples late in the bit since the slave path is synchronised
    task automatic frame(input logic [15:0] w, input int nbits, input logic sync);
        // framed: select sits at sync level for half a clock period first, while the clock is high
        peer_ss_n = sync;
        sdi = w[15];
        if (sync) begin
            peer_sck = 1'b1;
            #80;
            peer_sck = 1'b0;
            peer_ss_n = 1'b0;
            #80;
        end else begin
            #160;
        end
        for (int i = 0; i < nbits; i++) begin
            peer_sck = 1'b1;
            #80;
            gotw = {gotw[14:0], sdo};
            peer_sck = 1'b0;
            w = w << 1;
            sdi = w[15];
            #80;
        end
        peer_ss_n = 1'b1;
        sdi = ~sdi;
        got_q.push_back(gotw);
    endtask
endmodule
`default_nettype wire

// ### test/tb_spi_serial_port.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_spi_serial_port;
    import spi_serial_port_pkg::*;
    logic clk_sys = 0, reset_n = 0, cfg_write = 0, cfg_m = 0, cfg_ph = 0, cfg_ss = 0;
    logic cfg_frm = 0, cfg_en = 0, tx_valid = 0, peer_master = 0, seen, prev;
    logic [15:0] tx_data = 16'h0000;
    logic tx_ready, rx_valid, busy, tbf, sps, cinv, sdi, sdo, sdo_oe_n, pk, ps;
    logic sck_o, sck_oe_n, ss_o, ss_oe_n, sck_w, ss_w;
    logic [15:0] rx_data;
    logic [15:0] rx_q[$];
    int mismatches = 0, cmp_count = 0, n;
    always #10 clk_sys = ~clk_sys;
    // each pin resolves to whichever side drives it
    assign sck_w = sck_oe_n ? pk : sck_o;
    assign ss_w = ss_oe_n ? ps : ss_o;
    spi_serial_port u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_write(cfg_write),
        .cfg_port_enable(cfg_en), .cfg_master_mode_enable(cfg_m),
        .cfg_input_sample_phase(cfg_ph), .cfg_clock_idle_polarity(1'b0),
        .cfg_slave_select_pin_enable(cfg_ss), .cfg_framed_mode_enable(cfg_frm),
        .cfg_frame_sync_polarity(1'b1), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
        .transfer_buffer_full(tbf), .sample_phase_state(sps), .config_invalid(cinv),
        .serial_in_pin(sdi), .serial_out_pin(sdo), .serial_out_oe_n(sdo_oe_n),
        .shift_clock_in(sck_w), .shift_clock_out(sck_o), .shift_clock_oe_n(sck_oe_n),
        .slave_select_n_in(ss_w), .slave_select_n_out(ss_o),
        .slave_select_n_oe_n(ss_oe_n));
    spi_peer u_peer (.act_master(peer_master), .sck(sck_w), .ss_n(ss_w), .sdo(sdo),
        .sdi(sdi), .peer_sck(pk), .peer_ss_n(ps));
    always @(posedge clk_sys) if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] wd(input int i);
        return 16'ha5c3 ^ (16'(i) * 16'h0111);
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic m, input logic ph, input logic ss, input logic frm,
        input logic en);
        @(negedge clk_sys);
        {cfg_m, cfg_ph, cfg_ss, cfg_frm, cfg_en, cfg_write} = {m, ph, ss, frm, en, 1'b1};
        @(negedge clk_sys);
        cfg_write = 0;
        @(negedge clk_sys);
    endtask
    task automatic push(input logic [15:0] w);
        int k;
        k = 0;
        @(negedge clk_sys);
        tx_data = w;
        tx_valid = 1;
        while (tx_ready !== 1'b1 && k < 50) begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        tx_valid = 0;
    endtask
    task automatic wait_rx(input int cnt);
        for (int k = 0; k < 8000 && rx_q.size() < cnt; k++) @(negedge clk_sys);
        repeat (6) @(negedge clk_sys);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // whole run is some 5300 cycles; allow ample margin
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1;
        chk_bit(tx_ready, 1'b1);
        chk_bit(ss_o, 1'b1);
        chk_bit(sck_oe_n, 1'b1);
        cfg(0, 1, 0, 0, 0);
        chk_bit(sps, 1'b0);
        cfg(0, 0, 1, 1, 0);
        chk_bit(cinv, 1'b1);
        for (int ph = 0; ph < 2; ph++) begin
            u_peer.reply = 16'h3cc3 ^ 16'(ph);
            cfg(1, ph[0], 1, 0, 1);
            chk_bit(sps, ph[0]);
            rx_q.delete();
            u_peer.got_q.delete();
            push(wd(ph));
            for (int k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk_sys);
            repeat (20) @(negedge clk_sys);
            chk_bit(sck_oe_n, 1'b0);
            chk_bit(ss_o, 1'b0);
            chk_bit(ss_oe_n, 1'b0);
            chk_bit(tbf, 1'b0);
            wait_rx(1);
            chk_word(rx_q[0], 16'h3cc3 ^ 16'(ph));
            chk_word(u_peer.got_q[0], wd(ph));
        end
        // fill while disabled: fifo plus transfer buffer hold the words
        u_peer.reply = 16'h0ff0;
        cfg(1, 1, 1, 0, 0);
        rx_q.delete();
        u_peer.got_q.delete();
        n = 0;
        tx_data = wd(0);
        tx_valid = 1;
        for (int k = 0; k < 40; k++) begin
            if (tx_ready === 1'b1) n++;
            @(negedge clk_sys);
            tx_data = wd(n);
        end
        tx_valid = 0;
        chk_word(16'(n), 16'(FIFO_DEPTH + 1));
        chk_bit(tbf, 1'b1);
        cfg(1, 1, 1, 0, 1);
        wait_rx(n);
        for (int k = 0; k < n; k++) begin
            chk_word(u_peer.got_q[k], wd(k));
            chk_word(rx_q[k], 16'h0ff0);
        end
        // slave: remote master clocks the word in
        peer_master = 1;
        cfg(0, 0, 1, 0, 1);
        push(16'h1234);
        repeat (10) @(negedge clk_sys);
        chk_bit(sdo_oe_n, 1'b1);
        rx_q.delete();
        u_peer.got_q.delete();
        u_peer.frame(16'hc0de, 16, 1'b0);
        repeat (10) @(negedge clk_sys);
        chk_word(rx_q[0], 16'hc0de);
        chk_word(u_peer.got_q[0], 16'h1234);
        chk_bit(sck_oe_n, 1'b1);
        // deselect after half a word must abort without a word
        rx_q.delete();
        u_peer.frame(16'hffff, 8, 1'b0);
        repeat (20) @(negedge clk_sys);
        chk_word(16'(rx_q.size()), 16'h0000);
        chk_bit(busy, 1'b0);
        // framed slave: half a clock period at frame level, then the word
        cfg(0, 0, 0, 1, 1);
        push(16'h5aa5);
        rx_q.delete();
        u_peer.got_q.delete();
        u_peer.frame(16'h9bd1, 16, 1'b1);
        repeat (10) @(negedge clk_sys);
        chk_word(rx_q[0], 16'h9bd1);
        chk_word(u_peer.got_q[0], 16'h5aa5);
        // framed master: clock runs with nothing to send
        peer_master = 0;
        cfg(1, 0, 0, 1, 1);
        chk_bit(cinv, 1'b0);
        n = 0;
        prev = sck_o;
        repeat (80) begin
            @(negedge clk_sys);
            if (sck_o === 1'b1 && prev === 1'b0) n++;
            prev = sck_o;
        end
        chk_word(16'(n), 16'h000a);
        rx_q.delete();
        push(wd(7));
        seen = 0;
        repeat (60) begin
            @(negedge clk_sys);
            if (ss_o === 1'b1) seen = 1;
        end
        chk_bit(seen, 1'b1);
        wait_rx(1);
        chk_word(16'(rx_q.size()), 16'h0001);
        finish_test();
    end
endmodule
`default_nettype wire
